// File: src/code_detect.sv
`timescale 1ns/100ps
// Detects a repeating loop code held for a long interval
module code_detect #(
  parameter int unsigned        LEN  = 5,
  parameter logic [LEN-1:0]     CODE = '0,
  parameter int unsigned        HOLD = 200_000_000
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // Receive bit stream
  input  wire logic bit_en,
  input  wire logic bit_val,
  input  wire logic clear,
  // Result
  output logic      found
);

  logic [LEN-1:0] hist_q;
  logic [LEN-1:0] hist_d;
  logic [31:0]    hold_q;
  logic [31:0]    hold_d;
  logic           match;

  // Any rotation matches, so framing bits only restart the interval
  always_comb begin
    match = 1'b0;
    for (int i = 0; i < LEN; i++) begin
      if (hist_q == LEN'((CODE << i) | (CODE >> (LEN - i)))) begin
        match = 1'b1;
      end
    end
    hist_d = hist_q;
    hold_d = hold_q;
    if (clear) begin
      hold_d = 32'h0;
    end else if (bit_en) begin
      hist_d = {hist_q[LEN-2:0], bit_val};
      if (!match) begin
        hold_d = 32'h0;
      end else if (hold_q < 32'(HOLD)) begin
        hold_d = hold_q + 32'h1;
      end
    end else if (match && hold_q != 32'h0 && hold_q < 32'(HOLD)) begin
      hold_d = hold_q + 32'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hist_q <= '0;
      hold_q <= 32'h0;
    end else begin
      hist_q <= hist_d;
      hold_q <= hold_d;
    end
  end

  assign found = (hold_q >= 32'(HOLD));

endmodule

// File: src/edge_sync.sv
`timescale 1ns/100ps
// Two-flop synchroniser with rising and falling edge pulses
module edge_sync (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // Async input
  input  wire logic async_in,
  // Synchronised outputs
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic [2:0] sh_q;
  logic [2:0] sh_d;

  always_comb begin
    sh_d = {sh_q[1:0], async_in};
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sh_q <= 3'h0;
    end else begin
      sh_q <= sh_d;
    end
  end

  assign level = sh_q[1];
  assign rise  = sh_q[1] & ~sh_q[2];
  assign fall  = ~sh_q[1] & sh_q[2];

endmodule

// File: src/line_loopback_and_test_pattern_ctl.sv
`timescale 1ns/100ps
// Overview of operation
// - Local loop: receiver inhibited, tx clock and data go to receive outputs.
// - In local loop the attenuator select only enables or bypasses it.
// - In local loop the line still gets tx data or all ones.
// - Analog loop feeds transmit outputs back into the receive inputs.
// - Analog loop overrides every other loopback mode.
// - Remote loop ignores tx inputs and resends recovered data at recovered clock.
// - Network loop can start only while its detection is enabled.
// - Loop-up code 00001 held five seconds enters network loop.
// - Loop-down 001 for five seconds, remote, analog or disable ends it.
// - Network loop with local loop gives dual loopback.
// - Remote plus local: tx to receive outputs, line data back unattenuated.
// - All ones sent at tx clock rate, master clock when tx clock absent.
// - Remote loop suppresses all ones; all ones may coexist with local loop.
// - T1 source is a 2^20-1 sequence, at most 14 consecutive zeros.
// - E1 source is a 2^15-1 sequence with inverted output.
// - Select 10 picks pseudorandom mode and enables its detector.
// - Generator runs on tx clock, master clock when tx clock absent.
// - Error request rise inverts one bit, deferred past a forced one.
// - Violation request rise inserts a bipolar violation during test patterns.
// - Sync when under four errors in 128 bits, lost above four.
// - Transition flag set on sync change; interrupt unless clear/mask is 1.
// - Select 01 sends loop-up 00001, select 11 sends loop-down 001.
// - Violation request sampled on tx clock falling edge, rising change requests.
module line_loopback_and_test_pattern_ctl (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // Control bits
  input  wire logic local_loop_enable_bit,
  input  wire logic analog_loop_enable_bit,
  input  wire logic remote_loop_enable_bit,
  input  wire logic network_loop_detect_enable,
  input  wire logic all_ones_enable_bit,
  input  wire logic pattern_select_bit0,
  input  wire logic pattern_select_bit1,
  input  wire logic jitter_attenuator_select,
  input  wire logic e1_mode,
  input  wire logic pattern_sync_irq_clear_mask,
  // Framer transmit side (async pins)
  input  wire logic tx_clock,
  input  wire logic tx_data,
  input  wire logic logic_error_request,
  input  wire logic violation_request,
  // Line receive side (recovered clock and data, async)
  input  wire logic line_rx_clock,
  input  wire logic line_rx_data,
  // Jitter attenuator return path
  input  wire logic jitter_attenuator_data,
  // Framer receive outputs
  output logic      rx_clock_out,
  output logic      rx_data_out,
  // Line transmit outputs
  output logic      line_tx_clock,
  output logic      line_tx_data,
  output logic      line_tx_violation,
  // Path control to analog and attenuator blocks
  output logic      receiver_inhibit,
  output logic      analog_loop_route,
  output logic      jitter_attenuator_in_loop,
  output logic      coder_bypass,
  // Status
  output logic      network_loopback,
  output logic      dual_loopback,
  output logic      pattern_sync,
  output logic      pattern_sync_transition_flag,
  output logic      irq_n
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic tx_clock_lvl, tx_clock_rise, tx_clock_fall;
  logic rclk_lvl, rclk_rise, rclk_fall;
  logic txd_lvl, rxd_lvl, jad_lvl, ler_rise, vio_lvl;

  edge_sync u_tx_clock (.ref_clk(ref_clk), .srst(srst), .async_in(tx_clock),
                    .level(tx_clock_lvl), .rise(tx_clock_rise), .fall(tx_clock_fall));
  edge_sync u_rclk (.ref_clk(ref_clk), .srst(srst), .async_in(line_rx_clock),
                    .level(rclk_lvl), .rise(rclk_rise), .fall(rclk_fall));
  edge_sync u_txd  (.ref_clk(ref_clk), .srst(srst), .async_in(tx_data),
                    .level(txd_lvl), .rise(), .fall());
  edge_sync u_rxd  (.ref_clk(ref_clk), .srst(srst), .async_in(line_rx_data),
                    .level(rxd_lvl), .rise(), .fall());
  edge_sync u_jad  (.ref_clk(ref_clk), .srst(srst), .async_in(jitter_attenuator_data),
                    .level(jad_lvl), .rise(), .fall());
  edge_sync u_ler  (.ref_clk(ref_clk), .srst(srst), .async_in(logic_error_request),
                    .level(), .rise(ler_rise), .fall());
  edge_sync u_vio  (.ref_clk(ref_clk), .srst(srst), .async_in(violation_request),
                    .level(vio_lvl), .rise(), .fall());

  // ----------------------------------------------------------------
  // Transmit timing: tx clock, master fallback when absent
  // ----------------------------------------------------------------
  logic [7:0] loss_q, loss_d, div_q, div_d;
  logic       tx_clock_ok, mclk_tick, tx_bit_en, vio_prev_q, vio_prev_d;

  always_comb begin
    loss_d = tx_clock_rise ? 8'h0 : (tx_clock_ok ? loss_q + 8'h1 : loss_q);
    div_d  = (div_q == 8'(loop_test_pkg::MCLK_DIV - 1)) ? 8'h0 : div_q + 8'h1;
    // Violation request latched on the falling tx clock edge
    vio_prev_d = tx_clock_fall ? vio_lvl : vio_prev_q;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      loss_q     <= 8'h0;
      div_q      <= 8'h0;
      vio_prev_q <= 1'b0;
    end else begin
      loss_q     <= loss_d;
      div_q      <= div_d;
      vio_prev_q <= vio_prev_d;
    end
  end

  assign tx_clock_ok   = (loss_q < 8'(loop_test_pkg::TX_CLK_LOSS_CYCLES));
  assign mclk_tick = (div_q == 8'h0);
  assign tx_bit_en = tx_clock_ok ? tx_clock_rise : mclk_tick;

  logic vio_req;
  assign vio_req = tx_clock_fall & vio_lvl & ~vio_prev_q;

  // ----------------------------------------------------------------
  // Loopback mode resolution
  // ----------------------------------------------------------------
  loop_test_pkg::pat_sel_t pat_sel;
  logic up_found, dn_found, network_loopback_q, network_loopback_d, network_loopback_end;
  logic remote_loopback_eff, local_loopback_eff, test_pat, ones_on;

  assign pat_sel = loop_test_pkg::pat_sel_t'({pattern_select_bit1, pattern_select_bit0});

  // Network loop ends on loop-down, remote, analog or detect off
  assign network_loopback_end = dn_found | remote_loop_enable_bit | analog_loop_enable_bit
                   | ~network_loop_detect_enable;

  always_comb begin
    network_loopback_d = network_loopback_q;
    if (network_loopback_end) begin
      network_loopback_d = 1'b0;
    end else if (up_found) begin
      network_loopback_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      network_loopback_q <= 1'b0;
    end else begin
      network_loopback_q <= network_loopback_d;
    end
  end

  code_detect #(.LEN(loop_test_pkg::UP_CODE_LEN), .CODE(loop_test_pkg::UP_CODE),
                .HOLD(loop_test_pkg::LOOP_CODE_CYCLES)) u_up (
    .ref_clk(ref_clk), .srst(srst), .bit_en(rclk_rise), .bit_val(rxd_lvl),
    .clear(~network_loop_detect_enable | network_loopback_q), .found(up_found));
  code_detect #(.LEN(loop_test_pkg::DN_CODE_LEN), .CODE(loop_test_pkg::DN_CODE),
                .HOLD(loop_test_pkg::LOOP_CODE_CYCLES)) u_dn (
    .ref_clk(ref_clk), .srst(srst), .bit_en(rclk_rise), .bit_val(rxd_lvl),
    .clear(~network_loopback_q), .found(dn_found));

  // Analog loop masks all others
  assign remote_loopback_eff = ~analog_loop_enable_bit & (remote_loop_enable_bit | network_loopback_q);
  assign local_loopback_eff = ~analog_loop_enable_bit & local_loop_enable_bit;
  assign ones_on   = all_ones_enable_bit & ~remote_loopback_eff;
  assign test_pat  = (pat_sel != loop_test_pkg::PAT_NONE) & ~remote_loopback_eff;

  // ----------------------------------------------------------------
  // Pattern generator
  // ----------------------------------------------------------------
  logic [19:0] lfsr_q, lfsr_d;
  logic [3:0]  zrun_q, zrun_d;
  logic [2:0]  cidx_q, cidx_d;
  logic        ler_pend_q, ler_pend_d, gen_bit_q, gen_bit_d, fb, raw, jam;

  always_comb begin
    if (e1_mode) begin
      fb = lfsr_q[loop_test_pkg::E1_PRBS_LEN-1] ^ lfsr_q[loop_test_pkg::E1_PRBS_TAP-1];
      raw = ~lfsr_q[loop_test_pkg::E1_PRBS_LEN-1];
    end else begin
      fb = lfsr_q[loop_test_pkg::T1_PRBS_LEN-1] ^ lfsr_q[loop_test_pkg::T1_PRBS_TAP-1];
      raw = lfsr_q[loop_test_pkg::T1_PRBS_LEN-1];
    end
    jam = 1'b0;
    case (pat_sel)
      loop_test_pkg::PAT_PRBS: begin
        jam = ~e1_mode & ~raw & (zrun_q == 4'(loop_test_pkg::MAX_ZEROS));
        raw = raw | jam;
      end
      loop_test_pkg::PAT_UP: raw = loop_test_pkg::UP_CODE[3'(4) - cidx_q];
      loop_test_pkg::PAT_DOWN: raw = loop_test_pkg::DN_CODE[2'(2) - cidx_q[1:0]];
      default: raw = 1'b0;
    endcase
    lfsr_d     = lfsr_q;
    zrun_d     = zrun_q;
    cidx_d     = cidx_q;
    gen_bit_d  = gen_bit_q;
    ler_pend_d = ler_pend_q | (ler_rise & test_pat);
    if (tx_bit_en) begin
      lfsr_d = {lfsr_q[18:0], fb};
      zrun_d = raw ? 4'h0 : zrun_q + 4'h1;
      if (pat_sel == loop_test_pkg::PAT_UP) begin
        cidx_d = (cidx_q == 3'(loop_test_pkg::UP_CODE_LEN - 1)) ? 3'h0 : cidx_q + 3'h1;
      end else begin
        cidx_d = (cidx_q >= 3'(loop_test_pkg::DN_CODE_LEN - 1)) ? 3'h0 : cidx_q + 3'h1;
      end
      // A forced one is never inverted; the error waits a bit
      gen_bit_d  = raw ^ (ler_pend_q & ~jam);
      ler_pend_d = (ler_pend_q & jam) | (ler_rise & test_pat);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lfsr_q     <= 20'hfffff;
      zrun_q     <= 4'h0;
      cidx_q     <= 3'h0;
      gen_bit_q  <= 1'b0;
      ler_pend_q <= 1'b0;
    end else begin
      lfsr_q     <= (lfsr_d == 20'h0) ? 20'hfffff : lfsr_d;
      zrun_q     <= zrun_d;
      cidx_q     <= cidx_d;
      gen_bit_q  <= gen_bit_d;
      ler_pend_q <= ler_pend_d;
    end
  end

  // ----------------------------------------------------------------
  // Data paths
  // ----------------------------------------------------------------
  logic ltx_clk_q, ltx_clk_d, ltx_dat_q, ltx_dat_d, lviol_q, lviol_d;
  logic rxo_clk_q, rxo_clk_d, rxo_dat_q, rxo_dat_d, loc_dat;

  assign loc_dat = test_pat ? gen_bit_q : txd_lvl;

  always_comb begin
    ltx_clk_d = tx_clock_ok ? tx_clock_lvl : div_q < 8'(loop_test_pkg::MCLK_DIV / 2);
    ltx_dat_d = ones_on ? 1'b1 : loc_dat;
    lviol_d   = lviol_q;
    if (remote_loopback_eff) begin
      // Recovered timing, no attenuation on the return leg
      ltx_clk_d = rclk_lvl;
      ltx_dat_d = rxd_lvl;
      lviol_d   = 1'b0;
    end else if (vio_req && test_pat) begin
      lviol_d = 1'b1;
    end else if (tx_bit_en) begin
      lviol_d = 1'b0;
    end
    rxo_clk_d = rclk_lvl;
    rxo_dat_d = rxd_lvl;
    if (local_loopback_eff) begin
      rxo_clk_d = tx_clock_ok ? tx_clock_lvl : ltx_clk_d;
      rxo_dat_d = jitter_attenuator_select ? jad_lvl : loc_dat;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ltx_clk_q <= 1'b0;
      ltx_dat_q <= 1'b0;
      lviol_q   <= 1'b0;
      rxo_clk_q <= 1'b0;
      rxo_dat_q <= 1'b0;
    end else begin
      ltx_clk_q <= ltx_clk_d;
      ltx_dat_q <= ltx_dat_d;
      lviol_q   <= lviol_d;
      rxo_clk_q <= rxo_clk_d;
      rxo_dat_q <= rxo_dat_d;
    end
  end

  assign line_tx_clock     = ltx_clk_q;
  assign line_tx_data      = ltx_dat_q;
  assign line_tx_violation = lviol_q;
  assign rx_clock_out      = rxo_clk_q;
  assign rx_data_out       = rxo_dat_q;
  assign receiver_inhibit  = local_loopback_eff;
  assign analog_loop_route = analog_loop_enable_bit;
  assign coder_bypass      = remote_loopback_eff;
  assign jitter_attenuator_in_loop = local_loopback_eff & jitter_attenuator_select;
  assign network_loopback  = network_loopback_q;
  assign dual_loopback     = network_loopback_q & local_loop_enable_bit;

  // ----------------------------------------------------------------
  // Pattern detector, 128-bit blocks
  // ----------------------------------------------------------------
  logic [19:0] rlfsr_q, rlfsr_d;
  logic [6:0]  bcnt_q, bcnt_d;
  logic [7:0]  ecnt_q, ecnt_d;
  logic        sync_q, sync_d, tflag_q, tflag_d, rexp, rbit, det_on;

  assign det_on = (pat_sel == loop_test_pkg::PAT_PRBS);

  always_comb begin
    rbit = e1_mode ? ~rxd_lvl : rxd_lvl;
    rexp = e1_mode ? rlfsr_q[loop_test_pkg::E1_PRBS_LEN-1] ^ rlfsr_q[loop_test_pkg::E1_PRBS_TAP-1]
                   : rlfsr_q[loop_test_pkg::T1_PRBS_LEN-1] ^ rlfsr_q[loop_test_pkg::T1_PRBS_TAP-1];
    rlfsr_d = rlfsr_q;
    bcnt_d  = bcnt_q;
    ecnt_d  = ecnt_q;
    sync_d  = sync_q;
    if (!det_on) begin
      bcnt_d = 7'h0;
      ecnt_d = 8'h0;
      sync_d = 1'b0;
    end else if (rclk_rise) begin
      // Self-synchronising: received bits refill the register
      rlfsr_d = {rlfsr_q[18:0], rbit};
      bcnt_d  = bcnt_q + 7'h1;
      ecnt_d  = ecnt_q + {7'h0, (rbit != rexp)};
      if (bcnt_q == 7'(loop_test_pkg::BLOCK_BITS - 1)) begin
        if (ecnt_d < 8'(loop_test_pkg::SYNC_ERR_MAX)) begin
          sync_d = 1'b1;
        end else if (ecnt_d > 8'(loop_test_pkg::SYNC_ERR_MAX)) begin
          sync_d = 1'b0;
        end
        ecnt_d = 8'h0;
      end
    end
    // Set wins over clear in the same cycle
    tflag_d = (sync_d != sync_q) | (tflag_q & ~pattern_sync_irq_clear_mask);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rlfsr_q <= 20'h0;
      bcnt_q  <= 7'h0;
      ecnt_q  <= 8'h0;
      sync_q  <= 1'b0;
      tflag_q <= 1'b0;
    end else begin
      rlfsr_q <= rlfsr_d;
      bcnt_q  <= bcnt_d;
      ecnt_q  <= ecnt_d;
      sync_q  <= sync_d;
      tflag_q <= tflag_d;
    end
  end

  assign pattern_sync                 = sync_q;
  assign pattern_sync_transition_flag = tflag_q;
  assign irq_n = ~(tflag_q & ~pattern_sync_irq_clear_mask);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  analog_loopback_prio_a: assert property (analog_loop_enable_bit |-> !coder_bypass && !receiver_inhibit)
    else $error("analog loop not dominant");
  network_loopback_end_a: assert property (network_loopback_end |=> !network_loopback)
    else $error("network loop not ended");
  network_loopback_gate_a: assert property (!network_loop_detect_enable |=> !network_loopback)
    else $error("network loop without detect");
  dual_loop_a: assert property (dual_loopback |-> network_loopback && local_loop_enable_bit)
    else $error("dual loop mismatch");
  ones_remote_loopback_a: assert property (remote_loopback_eff ##1 remote_loopback_eff |=> line_tx_data == $past(rxd_lvl))
    else $error("remote loop data wrong");
  ones_out_a: assert property (ones_on && !remote_loopback_eff |=> line_tx_data)
    else $error("all ones not sent");
  tflag_set_a: assert property (sync_q != $past(sync_q) |-> tflag_q)
    else $error("transition flag missed");
  irq_mask_a: assert property (pattern_sync_irq_clear_mask |-> irq_n)
    else $error("masked interrupt asserted");
  det_off_a: assert property (!det_on |=> !pattern_sync)
    else $error("sync without detector");
  jam_a: assert property (jam && tx_bit_en |=> gen_bit_q)
    else $error("forced one inverted");

  cover_sync_c: cover property (!pattern_sync ##1 pattern_sync);
  cover_network_loopback_c: cover property (!network_loopback ##1 network_loopback);
  cover_viol_c: cover property (line_tx_violation);
  cover_dual_c: cover property (dual_loopback);

endmodule

// File: src/loop_test_pkg.sv
package loop_test_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 40_000_000;
  localparam int unsigned LOOP_CODE_SEC    = 5;
  localparam int unsigned LOOP_CODE_CYCLES = LOOP_CODE_SEC * CLK_HZ;

  // MCLK fallback: tx clock absent after this many ref_clk cycles
  localparam int unsigned TX_CLK_LOSS_CYCLES = 64;
  // Free-running master bit rate divider for fallback timing
  localparam int unsigned MCLK_DIV           = 26;

  // ----------------------------------------------------------------
  // Pattern generator
  // ----------------------------------------------------------------
  localparam int unsigned T1_PRBS_LEN  = 20;
  localparam int unsigned T1_PRBS_TAP  = 17;
  localparam int unsigned E1_PRBS_LEN  = 15;
  localparam int unsigned E1_PRBS_TAP  = 14;
  localparam int unsigned MAX_ZEROS    = 14;
  localparam int unsigned UP_CODE_LEN  = 5;
  localparam int unsigned DN_CODE_LEN  = 3;
  localparam logic [4:0]  UP_CODE      = 5'h01;
  localparam logic [2:0]  DN_CODE      = 3'h1;

  // ----------------------------------------------------------------
  // Detector
  // ----------------------------------------------------------------
  localparam int unsigned BLOCK_BITS   = 128;
  localparam int unsigned SYNC_ERR_MAX = 4;

  // Pattern select encodings {bit1, bit0}
  typedef enum logic [1:0] {
    PAT_NONE = 2'h0,
    PAT_UP   = 2'h1,
    PAT_PRBS = 2'h2,
    PAT_DOWN = 2'h3
  } pat_sel_t;

endpackage

// File: testbench/line_far_end_model.sv
`timescale 1ns/100ps
module line_far_end_model (
  // Bench control
  input  wire logic       tx_run,
  input  wire logic [1:0] rx_mode,
  input  wire logic       rx_level,
  // Line transmit from block
  input  wire logic       line_tx_data,
  // Framer clock and line receive
  output logic            tx_clock,
  output logic            line_rx_clock,
  output logic            line_rx_data
);
  // ----------------------------------------------------------------
  // Clocks
  // ----------------------------------------------------------------
  initial begin
    tx_clock = 1'b0;
    line_rx_clock = 1'b0;
    line_rx_data = 1'b0;
  end
  // A stopped framer holds its clock low, which exercises the fallback timing
  always #100 tx_clock = tx_run ? ~tx_clock : 1'b0;
  // Same rate as the framer, unrelated phase, so looped data is never resampled twice
  initial begin
    #37;
    forever #100 line_rx_clock = ~line_rx_clock;
  end
  // ----------------------------------------------------------------
  // Line data: fixed level, far-end loop of our transmit, or toggling
  // ----------------------------------------------------------------
  always @(negedge line_rx_clock) begin
    case (rx_mode)
      2'h0: line_rx_data <= rx_level;
      2'h1: line_rx_data <= line_tx_data;
      default: line_rx_data <= ~line_rx_data;
    endcase
  end
endmodule

// File: testbench/test_line_loopback_and_test_pattern_ctl.sv
`timescale 1ns/100ps
module test_line_loopback_and_test_pattern_ctl;
  localparam logic [9:0] C_LOC = 10'h200, C_ANA = 10'h100, C_REM = 10'h080, C_NET = 10'h040;
  localparam logic [9:0] C_ONE = 10'h020, C_PR = 10'h010, C_JA = 10'h004, C_E1 = 10'h002;
  localparam logic [9:0] C_MSK = 10'h001;
  logic       ref_clk = 1'b0;
  logic       srst = 1'b1;
  logic [9:0] ctl = 10'h000;
  logic       tx_data = 1'b0;
  logic       ja_data = 1'b0;
  logic       ler = 1'b0;
  logic       vreq = 1'b0;
  logic       tx_run = 1'b1;
  logic [1:0] rx_mode = 2'h0;
  logic       rx_level = 1'b0;
  logic       tx_clock, line_rx_clock, line_rx_data, rx_clock_out, rx_data_out;
  logic       line_tx_clock, line_tx_data, line_tx_violation, receiver_inhibit;
  logic       analog_loop_route, jitter_attenuator_in_loop, coder_bypass, network_loopback;
  logic       dual_loopback, pattern_sync, pattern_sync_transition_flag, irq_n;
  int         num_errors = 0;
  int         num_checks = 0;

  always #12.5 ref_clk = ~ref_clk;

  line_loopback_and_test_pattern_ctl line_loopback_and_test_pattern_ctl_inst (
    .ref_clk(ref_clk), .srst(srst),
    .local_loop_enable_bit(ctl[9]), .analog_loop_enable_bit(ctl[8]),
    .remote_loop_enable_bit(ctl[7]), .network_loop_detect_enable(ctl[6]),
    .all_ones_enable_bit(ctl[5]), .pattern_select_bit1(ctl[4]), .pattern_select_bit0(ctl[3]),
    .jitter_attenuator_select(ctl[2]), .e1_mode(ctl[1]), .pattern_sync_irq_clear_mask(ctl[0]),
    .tx_clock(tx_clock), .tx_data(tx_data), .logic_error_request(ler),
    .violation_request(vreq), .line_rx_clock(line_rx_clock), .line_rx_data(line_rx_data),
    .jitter_attenuator_data(ja_data), .rx_clock_out(rx_clock_out), .rx_data_out(rx_data_out),
    .line_tx_clock(line_tx_clock), .line_tx_data(line_tx_data),
    .line_tx_violation(line_tx_violation), .receiver_inhibit(receiver_inhibit),
    .analog_loop_route(analog_loop_route), .jitter_attenuator_in_loop(jitter_attenuator_in_loop),
    .coder_bypass(coder_bypass), .network_loopback(network_loopback),
    .dual_loopback(dual_loopback), .pattern_sync(pattern_sync),
    .pattern_sync_transition_flag(pattern_sync_transition_flag), .irq_n(irq_n)
  );

  line_far_end_model line_far_end_model_inst (
    .tx_run(tx_run), .rx_mode(rx_mode), .rx_level(rx_level), .line_tx_data(line_tx_data),
    .tx_clock(tx_clock), .line_rx_clock(line_rx_clock), .line_rx_data(line_rx_data)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %b seen %b", nm, exp, got);
      num_errors++;
    end
  endtask

  // Ten bit periods let the synchronisers and the path settle
  task automatic step(input logic [9:0] c, input logic td, input logic jd, input logic rl);
    @(posedge ref_clk);
    ctl <= c;
    tx_data <= td;
    ja_data <= jd;
    rx_level <= rl;
    repeat (80) @(posedge ref_clk);
    #1;
  endtask

  task automatic wait_sync(input logic v);
    for (int i = 0; i < 8000 && pattern_sync !== v; i++) @(posedge ref_clk);
    #1;
  endtask

  task automatic finish_test();
    if (num_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #2_000_000;
    num_errors++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    int n;
    logic prev;
    logic [9:0] ev;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk("irq_n", 1'b1, irq_n);
    chk("pattern_sync", 1'b0, pattern_sync);
    step(C_LOC, 1'b1, 1'b0, 1'b0);
    chk("receiver_inhibit", 1'b1, receiver_inhibit);
    chk("rx_data_out", 1'b1, rx_data_out);
    chk("line_tx_data", 1'b1, line_tx_data);
    step(C_LOC | C_JA, 1'b0, 1'b1, 1'b0);
    chk("jitter_attenuator_in_loop", 1'b1, jitter_attenuator_in_loop);
    chk("rx_data_out", 1'b1, rx_data_out);
    step(C_LOC | C_ONE, 1'b0, 1'b1, 1'b0);
    chk("rx_data_out", 1'b0, rx_data_out);
    chk("line_tx_data", 1'b1, line_tx_data);
    step(C_REM | C_ONE, 1'b1, 1'b0, 1'b0);
    chk("coder_bypass", 1'b1, coder_bypass);
    chk("line_tx_data", 1'b0, line_tx_data);
    chk("rx_data_out", 1'b0, rx_data_out);
    step(C_REM | C_LOC, 1'b1, 1'b0, 1'b0);
    chk("rx_data_out", 1'b1, rx_data_out);
    chk("line_tx_data", 1'b0, line_tx_data);
    step(C_ANA | C_REM, 1'b1, 1'b0, 1'b0);
    chk("analog_loop_route", 1'b1, analog_loop_route);
    chk("coder_bypass", 1'b0, coder_bypass);
    step(C_NET | C_LOC, 1'b0, 1'b0, 1'b0);
    chk("network_loopback", 1'b0, network_loopback);
    chk("dual_loopback", 1'b0, dual_loopback);
    @(posedge ref_clk);
    tx_run <= 1'b0;
    step(C_ONE, 1'b0, 1'b0, 1'b0);
    n = 0;
    prev = line_tx_clock;
    repeat (200) begin
      @(posedge ref_clk);
      #1;
      if (line_tx_clock !== prev) n++;
      prev = line_tx_clock;
    end
    chk("line_tx_clock", 1'b1, n > 2);
    chk("line_tx_data", 1'b1, line_tx_data);
    @(posedge ref_clk);
    tx_run <= 1'b1;
    rx_mode <= 2'h1;
    for (int e = 0; e < 2; e++) begin
      ev = (e == 1) ? C_E1 : 10'h000;
      step(C_PR | ev, 1'b0, 1'b0, 1'b0);
      wait_sync(1'b1);
      chk("pattern_sync", 1'b1, pattern_sync);
      chk("pattern_sync_transition_flag", 1'b1, pattern_sync_transition_flag);
      chk("irq_n", 1'b0, irq_n);
      @(posedge ref_clk);
      vreq <= 1'b1;
      for (n = 0; n < 100 && line_tx_violation !== 1'b1; n++) begin
        @(posedge ref_clk);
        #1;
      end
      chk("line_tx_violation", 1'b1, line_tx_violation);
      vreq <= 1'b0;
      ler <= 1'b1;
      repeat (40) @(posedge ref_clk);
      ler <= 1'b0;
      repeat (2100) @(posedge ref_clk);
      #1;
      chk("pattern_sync", 1'b1, pattern_sync);
      step(C_PR | ev | C_MSK, 1'b0, 1'b0, 1'b0);
      chk("pattern_sync_transition_flag", 1'b0, pattern_sync_transition_flag);
      chk("irq_n", 1'b1, irq_n);
      @(posedge ref_clk);
      rx_mode <= 2'h2;
      wait_sync(1'b0);
      chk("pattern_sync", 1'b0, pattern_sync);
      @(posedge ref_clk);
      rx_mode <= 2'h1;
    end
    finish_test();
  end
endmodule
